// ===== logic/bse_pkg.sv
/*
  Shared constants and types for the bit, shift and flag execution unit.
  Assumes a single clock and an 8-bit data path with a byte-wide flag register.
*/
// What this block does
// RULE_01 - Push copies a general register onto the stack in two cycles, flags unchanged.
// RULE_02 - Pop loads a general register from the stack in two cycles, flags unchanged.
// RULE_03 - I/O bit set forces one I/O bit to one in two cycles, no flags.
// RULE_04 - I/O bit clear forces one I/O bit to zero in two cycles, no flags.
// RULE_05 - Rotate up through carry, one cycle, updates zero, carry, negative, overflow.
// RULE_06 - Rotate down through carry, one cycle, updates zero, carry, negative, overflow.
// RULE_07 - Signed shift down keeps bit 7, one cycle, updates Z, C, N, V.
// RULE_08 - Bit to transfer flag copies a register bit into T, one cycle.
// RULE_09 - Transfer flag to bit writes T into a register bit, one cycle, no flags.
// RULE_10 - Global interrupt on sets the interrupt enable flag in one cycle only.
// RULE_11 - Global interrupt off clears the interrupt enable flag in one cycle only.
// RULE_12 - One-cycle instructions set and clear the overflow flag, nothing else.
// RULE_13 - One-cycle instructions set and clear the signed test flag, nothing else.
// RULE_14 - One-cycle instructions set and clear the half-carry flag, nothing else.
// RULE_15 - Zero-fill shifts fill with zero, one cycle, update Z, C, N, V.
// RULE_16 - Port in and out move a whole byte in one cycle, no flags.
// RULE_17 - Nibble swap exchanges register halves in one cycle, flags unchanged.
`default_nettype none
package bse_pkg;
  // Operations handed over by the instruction decoder
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_PORT_IN    = 5'h01,
    OP_PORT_OUT   = 5'h02,
    OP_PUSH       = 5'h03,
    OP_POP        = 5'h04,
    OP_IO_SET     = 5'h05,
    OP_IO_CLEAR   = 5'h06,
    OP_SHIFT_UP   = 5'h07,
    OP_SHIFT_DOWN = 5'h08,
    OP_ROT_UP     = 5'h09,
    OP_ROT_DOWN   = 5'h0a,
    OP_SIGNED_DN  = 5'h0b,
    OP_NIB_SWAP   = 5'h0c,
    OP_BIT_TO_T   = 5'h0d,
    OP_T_TO_BIT   = 5'h0e,
    OP_FLAG_SET   = 5'h0f,
    OP_FLAG_CLEAR = 5'h10
  } bse_op_e;

  // Flag register bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;

  // Wishbone byte offsets
  localparam logic [11:0] OFS_REG_BASE = 12'h000;
  localparam logic [11:0] OFS_FLAGS    = 12'h080;
  localparam logic [11:0] OFS_STATUS   = 12'h084;
  localparam logic [11:0] OFS_IO_BASE  = 12'h100;
  localparam logic [11:0] OFS_IO_END   = 12'h200;
  localparam int unsigned STAT_READY   = 0;
  localparam int unsigned STAT_BUSY    = 1;
  localparam int unsigned STAT_SP_LSB  = 8;

  // Cycle counts per instruction class
  localparam int unsigned CYC_STACK  = 2;
  localparam int unsigned CYC_IO_BIT = 2;
  localparam int unsigned CYC_SINGLE = 1;
endpackage : bse_pkg
`default_nettype wire

// ===== logic/bse_shf_if.sv
/*
  Interface between the execution unit and its shift unit.
  Assumes a purely combinational shift unit on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
interface bse_shf_if;
  import bse_pkg::*;
  bse_op_e    op;
  logic [7:0] operand;
  logic [7:0] flags_in;
  logic [7:0] result;
  logic [7:0] flags_out;
  modport client (output op, output operand, output flags_in,
                  input result, input flags_out);
  modport unit   (input op, input operand, input flags_in,
                  output result, output flags_out);
endinterface : bse_shf_if
`default_nettype wire

// ===== logic/bse_shift_unit.sv
/*
  Combinational shift, rotate and nibble swap with flag update.
  Assumes the caller registers result and flags.
*/
`timescale 1ns/10ps
`default_nettype none
module bse_shift_unit (
  bse_shf_if.unit shf
);
  import bse_pkg::*;
  logic shift_op;

  // Result and carry per operation
  always_comb begin
    shf.result    = shf.operand;
    shf.flags_out = shf.flags_in;
    shift_op      = 1'b1;
    unique case (shf.op)
      OP_SHIFT_UP: begin
        shf.result = {shf.operand[6:0], 1'b0};                     // [RULE_15]
        shf.flags_out[FLG_C] = shf.operand[7];
      end
      OP_SHIFT_DOWN: begin
        shf.result = {1'b0, shf.operand[7:1]};                     // [RULE_15]
        shf.flags_out[FLG_C] = shf.operand[0];
      end
      OP_ROT_UP: begin
        shf.result = {shf.operand[6:0], shf.flags_in[FLG_C]};      // [RULE_05]
        shf.flags_out[FLG_C] = shf.operand[7];
      end
      OP_ROT_DOWN: begin
        shf.result = {shf.flags_in[FLG_C], shf.operand[7:1]};      // [RULE_06]
        shf.flags_out[FLG_C] = shf.operand[0];
      end
      OP_SIGNED_DN: begin
        shf.result = {shf.operand[7], shf.operand[7:1]};           // [RULE_07]
        shf.flags_out[FLG_C] = shf.operand[0];
      end
      OP_NIB_SWAP: begin
        shf.result = {shf.operand[3:0], shf.operand[7:4]};         // [RULE_17]
        shift_op   = 1'b0;
      end
      default: shift_op = 1'b0;
    endcase
    // Zero, negative and overflow from the shifted value
    if (shift_op) begin
      shf.flags_out[FLG_Z] = (shf.result == 8'h00);
      shf.flags_out[FLG_N] = shf.result[7];
      shf.flags_out[FLG_V] = shf.result[7] ^ shf.flags_out[FLG_C];
    end
  end
endmodule : bse_shift_unit
`default_nettype wire

// ===== logic/bse_bit_mod.sv
/*
  Replaces one selected bit of a byte with a given value.
  Assumes a bit index in the range 0 to 7.
*/
`timescale 1ns/10ps
`default_nettype none
module bse_bit_mod (
  input  wire logic [7:0] value_i,
  input  wire logic [2:0] bit_i,
  input  wire logic       bit_val_i,
  output logic      [7:0] result_o
);
  // One multiplexer per bit
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      result_o[i] = (bit_i == 3'(i)) ? bit_val_i : value_i[i];
    end
  end
endmodule : bse_bit_mod
`default_nettype wire

// ===== logic/bse_exec_unit.sv
/*
  Execution unit for stack, I/O bit, shift, bit transfer and flag instructions,
  with register file, I/O space, stack memory and a classic Wishbone slave.
  Assumes the decoder holds op_valid_i and operands until op_ready_o is high.
*/
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module bse_exec_unit #(
  parameter int unsigned NUM_REGS    = 32,
  parameter int unsigned IO_DEPTH    = 64,
  parameter int unsigned STACK_DEPTH = 64
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [11:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             op_valid_i,
  input  wire bse_pkg::bse_op_e op_code_i,
  input  wire logic [4:0]       op_reg_i,
  input  wire logic [2:0]       op_bit_i,
  input  wire logic [5:0]       op_io_i,
  output logic                  op_ready_o,
  output logic                  op_done_o,
  output logic      [7:0]       flags_o
);
  import bse_pkg::*;
  localparam int unsigned RW  = $clog2(NUM_REGS);
  localparam int unsigned IW  = $clog2(IO_DEPTH);
  localparam int unsigned SPW = $clog2(STACK_DEPTH);

  typedef enum logic {ST_IDLE = 1'b0, ST_SECOND = 1'b1} bse_state_e;

  bse_state_e state;
  logic [7:0] regs  [NUM_REGS];
  logic [7:0] io    [IO_DEPTH];
  logic [7:0] stack [STACK_DEPTH];
  logic [SPW-1:0] sp;
  logic [7:0] flag_register;
  bse_op_e    lat_op;
  logic [4:0] lat_reg;
  logic [2:0] lat_bit;
  logic [5:0] lat_io;
  logic [7:0] lat_data;
  logic       accept;
  logic       two_cycle;
  logic       wb_req;
  logic       wb_go;
  logic       wb_wr;
  logic       wb_in_regs;
  logic       wb_in_io;
  logic [7:0] rd_val;
  logic [7:0] bm_value;
  logic [2:0] bm_bit;
  logic       bm_val;
  logic [7:0] bm_result;
  logic [31:0] wb_status;
  logic [31:0] next_rdata;

  bse_shf_if shf ();

  // Operand fetch and shift unit hookup
  assign rd_val       = regs[op_reg_i[RW-1:0]];
  assign shf.op       = op_code_i;
  assign shf.operand  = rd_val;
  assign shf.flags_in = flag_register;
  assign flags_o      = flag_register;

  bse_shift_unit u_shift (
    .shf (shf)
  );

  // Bit modifier: I/O bit ops in the second cycle, T load otherwise
  assign bm_value = (state == ST_SECOND) ? lat_data : rd_val;
  assign bm_bit   = (state == ST_SECOND) ? lat_bit : op_bit_i;
  assign bm_val   = (state == ST_SECOND) ? (lat_op == OP_IO_SET) : flag_register[FLG_T];

  bse_bit_mod u_bit_mod (
    .value_i   (bm_value),
    .bit_i     (bm_bit),
    .bit_val_i (bm_val),
    .result_o  (bm_result)
  );

  // Handshake and bus arbitration; instructions win over the bus
  assign accept    = op_valid_i & op_ready_o;
  assign two_cycle = (op_code_i == OP_PUSH) || (op_code_i == OP_POP) ||
                     (op_code_i == OP_IO_SET) || (op_code_i == OP_IO_CLEAR);
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_go      = wb_req & (state == ST_IDLE) & ~accept;
  assign wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wb_in_regs = (wb_adr_i < OFS_FLAGS);
  assign wb_in_io   = (wb_adr_i >= OFS_IO_BASE) && (wb_adr_i < OFS_IO_END);

  // Sequencer for one- and two-cycle instructions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      op_ready_o <= 1'b0;
      op_done_o  <= 1'b0;
    end else begin
      op_done_o <= (accept & ~two_cycle) | (state == ST_SECOND);
      if (accept && two_cycle) begin
        state      <= ST_SECOND;                                   // [RULE_01] [RULE_03]
        op_ready_o <= 1'b0;
      end else begin
        state      <= ST_IDLE;
        op_ready_o <= ~wb_go;
      end
    end
  end

  // Operand latches for the second cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_op   <= OP_NOP;
      lat_reg  <= 5'h00;
      lat_bit  <= 3'h0;
      lat_io   <= 6'h00;
      lat_data <= 8'h00;
    end else if (accept) begin
      lat_op   <= op_code_i;
      lat_reg  <= op_reg_i;
      lat_bit  <= op_bit_i;
      lat_io   <= op_io_i;
      lat_data <= io[op_io_i[IW-1:0]];                             // [RULE_03] [RULE_04]
    end
  end

  // General register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (state == ST_SECOND && lat_op == OP_POP) begin
      regs[lat_reg[RW-1:0]] <= stack[sp];                          // [RULE_02]
    end else if (accept) begin
      unique case (op_code_i)
        OP_PORT_IN:    regs[op_reg_i[RW-1:0]] <= io[op_io_i[IW-1:0]]; // [RULE_16]
        OP_SHIFT_UP, OP_SHIFT_DOWN, OP_ROT_UP, OP_ROT_DOWN, OP_SIGNED_DN,
        OP_NIB_SWAP:   regs[op_reg_i[RW-1:0]] <= shf.result;       // [RULE_05] [RULE_17]
        OP_T_TO_BIT:   regs[op_reg_i[RW-1:0]] <= bm_result;        // [RULE_09]
        default:       ;
      endcase
    end else if (wb_wr && wb_in_regs) begin
      regs[wb_adr_i[2 +: RW]] <= wb_dat_i[7:0];
    end
  end

  // I/O space
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < IO_DEPTH; i++) begin
        io[i] <= 8'h00;
      end
    end else if (state == ST_SECOND &&
                 (lat_op == OP_IO_SET || lat_op == OP_IO_CLEAR)) begin
      io[lat_io[IW-1:0]] <= bm_result;                             // [RULE_03] [RULE_04]
    end else if (accept && op_code_i == OP_PORT_OUT) begin
      io[op_io_i[IW-1:0]] <= rd_val;                               // [RULE_16]
    end else if (wb_wr && wb_in_io) begin
      io[wb_adr_i[2 +: IW]] <= wb_dat_i[7:0];
    end
  end

  // Stack memory, written in the first push cycle
  always_ff @(posedge clk_i) begin
    if (accept && op_code_i == OP_PUSH) begin
      stack[sp] <= rd_val;                                         // [RULE_01]
    end
  end

  // Stack pointer: post-decrement on push, pre-increment on pop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp <= SPW'(STACK_DEPTH - 1);
    end else if (state == ST_SECOND && lat_op == OP_PUSH) begin
      sp <= sp - 1'b1;                                             // [RULE_01]
    end else if (accept && op_code_i == OP_POP) begin
      sp <= sp + 1'b1;                                             // [RULE_02]
    end
  end

  // Flag register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_register <= FLAGS_RST;
    end else if (accept) begin
      unique case (op_code_i)
        OP_SHIFT_UP, OP_SHIFT_DOWN, OP_ROT_UP, OP_ROT_DOWN,
        OP_SIGNED_DN:  flag_register <= shf.flags_out;             // [RULE_05] [RULE_07]
        OP_BIT_TO_T:   flag_register[FLG_T] <= rd_val[op_bit_i];   // [RULE_08]
        OP_FLAG_SET:   flag_register[op_bit_i] <= 1'b1;  // [RULE_10] [RULE_12] [RULE_14]
        OP_FLAG_CLEAR: flag_register[op_bit_i] <= 1'b0;  // [RULE_11] [RULE_13] [RULE_14]
        default:       ;
      endcase
    end else if (wb_wr && wb_adr_i == OFS_FLAGS) begin
      flag_register <= wb_dat_i[7:0];
    end
  end

  // Read data selection
  always_comb begin
    wb_status                            = 32'h0000_0000;
    wb_status[STAT_READY]                = op_ready_o;
    wb_status[STAT_BUSY]                 = (state == ST_SECOND);
    wb_status[STAT_SP_LSB +: SPW]        = sp;
    next_rdata                           = 32'h0000_0000;
    if (wb_in_regs) begin
      next_rdata[7:0] = regs[wb_adr_i[2 +: RW]];
    end else if (wb_in_io) begin
      next_rdata[7:0] = io[wb_adr_i[2 +: IW]];
    end else if (wb_adr_i == OFS_FLAGS) begin
      next_rdata[7:0] = flag_register;
    end else if (wb_adr_i == OFS_STATUS) begin
      next_rdata = wb_status;
    end
  end

  // Wishbone acknowledge, one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PUSH_TWO_CYCLES: assert property ( // [RULE_01]
    accept && op_code_i == OP_PUSH |=> state == ST_SECOND && !op_done_o
      ##1 op_done_o && flag_register == $past(flag_register, 2)
      && stack[$past(sp, 2)] == $past(rd_val, 2))
    else $error("push did not finish in two cycles with flags kept");

  AST_POP_LOADS: assert property ( // [RULE_02]
    state == ST_SECOND && lat_op == OP_POP |=> op_done_o
      && regs[$past(lat_reg)] == $past(stack[sp]) && $stable(flag_register))
    else $error("pop did not load the register from the stack");

  AST_IO_SET: assert property ( // [RULE_03]
    accept && op_code_i == OP_IO_SET |-> ##2
      io[$past(op_io_i, 2)][$past(op_bit_i, 2)] && op_done_o
      && flag_register == $past(flag_register, 2))
    else $error("I/O bit set wrong");

  AST_IO_CLEAR: assert property ( // [RULE_04]
    accept && op_code_i == OP_IO_CLEAR |-> ##2
      !io[$past(op_io_i, 2)][$past(op_bit_i, 2)] && op_done_o
      && flag_register == $past(flag_register, 2))
    else $error("I/O bit clear wrong");

  AST_ROT_UP: assert property ( // [RULE_05]
    accept && op_code_i == OP_ROT_UP |=> op_done_o
      && regs[$past(op_reg_i)] == {$past(rd_val[6:0]), $past(flag_register[FLG_C])}
      && flag_register[FLG_C] == $past(rd_val[7]))
    else $error("rotate up through carry wrong");

  AST_ROT_DOWN: assert property ( // [RULE_06]
    accept && op_code_i == OP_ROT_DOWN |=>
      regs[$past(op_reg_i)] == {$past(flag_register[FLG_C]), $past(rd_val[7:1])}
      && flag_register[FLG_C] == $past(rd_val[0]))
    else $error("rotate down through carry wrong");

  AST_SIGNED_DN: assert property ( // [RULE_07]
    accept && op_code_i == OP_SIGNED_DN |=>
      regs[$past(op_reg_i)] == {$past(rd_val[7]), $past(rd_val[7:1])}
      && flag_register[FLG_V] == (flag_register[FLG_N] ^ flag_register[FLG_C]))
    else $error("signed shift down wrong");

  AST_BIT_TO_T: assert property ( // [RULE_08]
    accept && op_code_i == OP_BIT_TO_T |=>
      flag_register[FLG_T] == $past(rd_val[op_bit_i])
      && flag_register[5:0] == $past(flag_register[5:0]))
    else $error("bit to transfer flag wrong");

  AST_T_TO_BIT: assert property ( // [RULE_09]
    accept && op_code_i == OP_T_TO_BIT |=>
      regs[$past(op_reg_i)][$past(op_bit_i)] == $past(flag_register[FLG_T])
      && $stable(flag_register))
    else $error("transfer flag to bit wrong");

  AST_IRQ_ON: assert property ( // [RULE_10]
    accept && op_code_i == OP_FLAG_SET && op_bit_i == 3'(FLG_I) |=>
      flag_register == ($past(flag_register) | 8'h80))
    else $error("global interrupt enable not set alone");

  AST_FLAG_CLEAR: assert property ( // [RULE_11]
    accept && op_code_i == OP_FLAG_CLEAR |=>
      !flag_register[$past(op_bit_i)] && op_done_o)
    else $error("flag clear wrong");

  AST_ZERO_FILL: assert property ( // [RULE_15]
    accept && op_code_i == OP_SHIFT_DOWN |=>
      regs[$past(op_reg_i)] == {1'b0, $past(rd_val[7:1])} && !flag_register[FLG_N])
    else $error("zero-fill shift down wrong");

  AST_NIB_SWAP: assert property ( // [RULE_17]
    accept && op_code_i == OP_NIB_SWAP |=>
      regs[$past(op_reg_i)] == {$past(rd_val[3:0]), $past(rd_val[7:4])}
      && $stable(flag_register))
    else $error("nibble swap wrong");

  CVR_PUSH:   cover property (accept && op_code_i == OP_PUSH ##2 op_done_o);
  CVR_IO_SET: cover property (accept && op_code_i == OP_IO_SET);
  CVR_ROT:    cover property (accept && op_code_i == OP_ROT_UP && flag_register[FLG_C]);
  CVR_WB:     cover property (wb_go ##1 wb_ack_o);
endmodule : bse_exec_unit
`default_nettype wire

// ===== tb/bse_decoder_model.sv
/*
  Decoder stand-in: presents queued operations to the execution unit.
  Assumes the bench fills pend and sets gap through hierarchical reference.
*/
`timescale 1ns/10ps
`default_nettype none
module bse_decoder_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       op_ready_i,
  output logic            op_valid_o,
  output bse_pkg::bse_op_e op_code_o,
  output logic      [4:0] op_reg_o,
  output logic      [2:0] op_bit_o,
  output logic      [5:0] op_io_o
);
  import bse_pkg::*;
  typedef struct packed {
    bse_op_e    code;
    logic [4:0] r;
    logic [2:0] b;
    logic [5:0] io;
  } bse_req_s;
  bse_req_s    pend[$];
  int unsigned nxt  = 0;
  int unsigned gap  = 0;
  int unsigned idle = 0;
  // Known levels before the first edge
  initial begin
    op_valid_o = 1'b0;
    op_code_o  = OP_NOP;
    op_reg_o   = 5'h00;
    op_bit_o   = 3'h0;
    op_io_o    = 6'h00;
  end
  // Hold a request until taken, then present the next after gap idle cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      op_valid_o <= 1'b0;
    end else if (!op_valid_o || op_ready_i) begin
      if (nxt < pend.size() && idle == 0) begin
        op_valid_o <= 1'b1;
        op_code_o  <= pend[nxt].code;
        op_reg_o   <= pend[nxt].r;
        op_bit_o   <= pend[nxt].b;
        op_io_o    <= pend[nxt].io;
        nxt        <= nxt + 1;
        idle       <= gap;
      end else begin
        // Released operands invert each idle cycle, so the last value returns every second cycle
        op_valid_o <= 1'b0;
        op_code_o  <= OP_NOP;
        op_reg_o   <= ~op_reg_o;
        op_bit_o   <= ~op_bit_o;
        op_io_o    <= ~op_io_o;
        if (idle != 0) begin
          idle <= idle - 1;
        end
      end
    end
  end
endmodule : bse_decoder_model
`default_nettype wire

// ===== tb/bse_exec_unit_tb.sv
/*
  Self-checking bench for the execution unit: Wishbone register access
  plus instructions fed through the decoder stand-in. Assumes one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bse_exec_unit_tb;
  import bse_pkg::*;
  localparam int unsigned SDEPTH = 64;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        op_valid, op_ready, op_done;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [7:0]  flags_o;
  logic [4:0]  op_reg;
  logic [2:0]  op_bit;
  logic [5:0]  op_io;
  bse_op_e     op_code;
  int          bad_count = 0;
  int          total_checks = 0;
  bse_exec_unit #(.NUM_REGS(32), .IO_DEPTH(64), .STACK_DEPTH(SDEPTH)) bse_exec_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .op_valid_i(op_valid), .op_code_i(op_code), .op_reg_i(op_reg),
    .op_bit_i(op_bit), .op_io_i(op_io), .op_ready_o(op_ready), .op_done_o(op_done),
    .flags_o(flags_o));
  bse_decoder_model bse_decoder_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .op_ready_i(op_ready), .op_valid_o(op_valid),
    .op_code_o(op_code), .op_reg_o(op_reg), .op_bit_o(op_bit), .op_io_o(op_io));
  // Clock source
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [11:0] radr(input logic [4:0] n);
    return OFS_REG_BASE + {5'h00, n, 2'b00};
  endfunction : radr
  function automatic logic [11:0] iadr(input logic [5:0] n);
    return OFS_IO_BASE + {4'h0, n, 2'b00};
  endfunction : iadr
  // Classic single cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_sel  <= 4'h1;
    wb_wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    check("ack", 32'h1, {31'h0, wb_ack});
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] e);
    wb_xfer(1'b0, a, 8'h00);
    check(what, {24'h000000, e}, rd);
  endtask : rd_chk
  // Queue one operation, then measure take-to-done latency
  task automatic run_op(input bse_op_e c, input logic [4:0] r, input logic [2:0] b,
                        input logic [5:0] io, input int cyc);
    int k;
    bse_decoder_model_i.pend.push_back('{c, r, b, io});
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(op_valid === 1'b1 && op_ready === 1'b1) && k < 50);
    check("taken", 32'h1, {31'h0, op_valid & op_ready});
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (op_done !== 1'b1 && k < 8);
    check("latency", cyc, k);
  endtask : run_op
  function automatic logic [15:0] exp_shift(input bse_op_e op, input logic [7:0] v,
                                            input logic [7:0] f);
    logic [7:0] r;
    logic       c;
    case (op)
      OP_SHIFT_UP:   {c, r} = {v, 1'b0};
      OP_SHIFT_DOWN: {r, c} = {1'b0, v};
      OP_ROT_UP:     {c, r} = {v, f[FLG_C]};
      OP_ROT_DOWN:   {r, c} = {f[FLG_C], v};
      OP_SIGNED_DN:  {r, c} = {v[7], v};
      default:       return {f, v[3:0], v[7:4]};
    endcase
    f[FLG_C] = c;
    f[FLG_Z] = (r == 8'h00);
    f[FLG_N] = r[7];
    f[FLG_V] = r[7] ^ c;
    return {f, r};
  endfunction : exp_shift
  task automatic shift_case(input bse_op_e op, input logic [7:0] v, input logic [7:0] f);
    logic [15:0] e;
    e = exp_shift(op, v, f);
    wb_xfer(1'b1, radr(5'd1), v);
    wb_xfer(1'b1, OFS_FLAGS, f);
    run_op(op, 5'd1, 3'd0, 6'd0, CYC_SINGLE);
    check("flags", {24'h0, e[15:8]}, {24'h0, flags_o});
    rd_chk("result", radr(5'd1), e[7:0]);
  endtask : shift_case
  task automatic test_reset;
    check("flags", {24'h0, FLAGS_RST}, {24'h0, flags_o});
    rd_chk("reg", radr(5'd3), 8'h00);
    wb_xfer(1'b1, 12'h090, 8'h5a);
    rd_chk("unmapped", 12'h090, 8'h00);
    wb_xfer(1'b0, OFS_STATUS, 8'h00);
    check("sp", SDEPTH - 1, {26'h0, rd[13:8]});
    $display("reset test done");
  endtask : test_reset
  task automatic test_shifts;
    shift_case(OP_SHIFT_UP, 8'h80, 8'h30);
    shift_case(OP_SHIFT_DOWN, 8'h01, 8'h30);
    shift_case(OP_ROT_UP, 8'h55, 8'h31);
    shift_case(OP_ROT_DOWN, 8'h02, 8'h21);
    shift_case(OP_SIGNED_DN, 8'h81, 8'h10);
    shift_case(OP_NIB_SWAP, 8'h3c, 8'h9b);
    $display("shift test done");
  endtask : test_shifts
  task automatic test_back_to_back;
    wb_xfer(1'b1, radr(5'd2), 8'h81);
    wb_xfer(1'b1, OFS_FLAGS, 8'h00);
    bse_decoder_model_i.pend.push_back('{OP_ROT_UP, 5'd2, 3'd0, 6'd0});
    run_op(OP_ROT_UP, 5'd2, 3'd0, 6'd0, CYC_SINGLE);
    @(posedge clk_i);
    check("second done", 1, {31'h0, op_done});
    check("flags", 8'h00, {24'h0, flags_o});
    rd_chk("result", radr(5'd2), 8'h05);
    $display("back to back test done");
  endtask : test_back_to_back
  task automatic test_stack;
    bse_decoder_model_i.gap = 2;
    wb_xfer(1'b1, radr(5'd5), 8'ha5);
    wb_xfer(1'b1, OFS_FLAGS, 8'h5a);
    run_op(OP_PUSH, 5'd5, 3'd0, 6'd0, CYC_STACK);
    check("flags", 8'h5a, {24'h0, flags_o});
    wb_xfer(1'b0, OFS_STATUS, 8'h00);
    check("sp", SDEPTH - 2, {26'h0, rd[13:8]});
    run_op(OP_POP, 5'd7, 3'd0, 6'd0, CYC_STACK);
    check("flags", 8'h5a, {24'h0, flags_o});
    rd_chk("popped", radr(5'd7), 8'ha5);
    bse_decoder_model_i.gap = 0;
    $display("stack test done");
  endtask : test_stack
  task automatic test_io;
    wb_xfer(1'b1, iadr(6'd9), 8'h0f);
    wb_xfer(1'b1, OFS_FLAGS, 8'h96);
    run_op(OP_IO_SET, 5'd0, 3'd6, 6'd9, CYC_IO_BIT);
    rd_chk("io set", iadr(6'd9), 8'h4f);
    run_op(OP_IO_CLEAR, 5'd0, 3'd0, 6'd9, CYC_IO_BIT);
    rd_chk("io clear", iadr(6'd9), 8'h4e);
    run_op(OP_PORT_IN, 5'd2, 3'd0, 6'd9, CYC_SINGLE);
    run_op(OP_PORT_OUT, 5'd2, 3'd0, 6'd10, CYC_SINGLE);
    rd_chk("port out", iadr(6'd10), 8'h4e);
    check("flags", 8'h96, {24'h0, flags_o});
    $display("io test done");
  endtask : test_io
  task automatic test_bit_xfer;
    wb_xfer(1'b1, radr(5'd4), 8'h10);
    wb_xfer(1'b1, radr(5'd6), 8'h01);
    wb_xfer(1'b1, OFS_FLAGS, 8'h00);
    run_op(OP_BIT_TO_T, 5'd4, 3'd4, 6'd0, CYC_SINGLE);
    check("flags", 8'h40, {24'h0, flags_o});
    run_op(OP_T_TO_BIT, 5'd6, 3'd7, 6'd0, CYC_SINGLE);
    check("flags", 8'h40, {24'h0, flags_o});
    rd_chk("bit load", radr(5'd6), 8'h81);
    run_op(OP_BIT_TO_T, 5'd4, 3'd0, 6'd0, CYC_SINGLE);
    check("flags", 8'h00, {24'h0, flags_o});
    $display("bit transfer test done");
  endtask : test_bit_xfer
  task automatic test_flags;
    logic [8:0] m;
    wb_xfer(1'b1, OFS_FLAGS, 8'h00);
    for (int b = 0; b < 8; b++) begin
      m = (9'h002 << b) - 9'h001;
      run_op(OP_FLAG_SET, 5'd0, b[2:0], 6'd0, CYC_SINGLE);
      check("flag set", m[7:0], {24'h0, flags_o});
    end
    for (int b = 0; b < 8; b++) begin
      m = (9'h002 << b) - 9'h001;
      run_op(OP_FLAG_CLEAR, 5'd0, b[2:0], 6'd0, CYC_SINGLE);
      check("flag clr", {24'h0, ~m[7:0]}, {24'h0, flags_o});
    end
    $display("flag test done");
  endtask : test_flags
  // Main sequence
  initial begin
    rst_i   = 1'b1;
    wb_cyc  = 1'b0;
    wb_stb  = 1'b0;
    wb_we   = 1'b0;
    wb_adr  = 12'h000;
    wb_sel  = 4'h0;
    wb_wdat = 32'h00000000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_shifts();
    test_back_to_back();
    test_stack();
    test_io();
    test_bit_xfer();
    test_flags();
    print_verdict();
  end
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : bse_exec_unit_tb
`default_nettype wire
